// >>> dgct_pkg.sv
/*
 Shared constants for the geardown and command timing link: command codes,
 mode register bit positions and cycle counts at the 125 MHz core clock.
 Assumes both ends run on the same core_clk.
*/
package dgct_pkg;
    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 8000;
    // Times in nanoseconds as defaults; cycles rounded up
    localparam int MODE_UPDATE_NS = 15;
    localparam int MODE_UPDATE_CYC = (MODE_UPDATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESET_EXIT_NS = 360;
    localparam int RESET_EXIT_CYC = (RESET_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SREF_EXIT_NS = 360;
    localparam int SREF_EXIT_CYC = (SREF_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_RECOVERY_NS = 15;
    localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_RECOVERY_CM_NS = 20;
    localparam int WRITE_RECOVERY_CM_CYC = (WRITE_RECOVERY_CM_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WTR_SHORT_CYC = 2;
    localparam int WTR_SHORT_CM_CYC = 4;
    localparam int WTR_LONG_CYC = 6;
    localparam int WTR_LONG_CM_CYC = 8;
    localparam int SYNC_EXTRA_CYC = 4;
    localparam int SYNC_SETUP_CYC = 2;
    localparam int SYNC_HOLD_CYC = 2;
    localparam int MR7_GAP_CYC = 5;
    localparam int MPR_GAP_CYC = 4;
    localparam int WSTART_FULL_CYC = 4;
    localparam int WSTART_CHOP_CYC = 2;
    localparam int BURST_CYC = 4;
    localparam int BG_OP_CYC = 8;
    localparam int MIN_RATE_MTS = 1600;
    // Mode register bit positions and select codes
    localparam int MR4_RD_PRE_BIT = 11;
    localparam int MR4_WR_PRE_BIT = 12;
    localparam int MR4_GEAR_BIT = 3;
    localparam logic [2:0] MR_SEL_FOUR = 3'h4;
    localparam logic [2:0] MR_SEL_THREE = 3'h3;
    localparam logic [2:0] MR_SEL_SEVEN = 3'h7;
    localparam int MR3_MPR_BIT = 2;
    // Command codes on the link
    typedef enum logic [2:0] {
        DGCT_CMD_DES = 3'h0,
        DGCT_CMD_MRW = 3'h1,
        DGCT_CMD_ACT = 3'h2,
        DGCT_CMD_PRE = 3'h3,
        DGCT_CMD_RD = 3'h4,
        DGCT_CMD_RDA = 3'h5,
        DGCT_CMD_WR = 3'h6,
        DGCT_CMD_REF = 3'h7
    } dgct_cmd_t;
endpackage

// >>> dgct_if.sv
/*
 Command link between the host controller end and the memory device end.
 Assumes a common core_clk; the testbench instantiates and joins it.
*/
`timescale 1ns/100ps
interface dgct_if;
    logic cke;
    logic cs_n;
    logic [2:0] cmd;
    logic [2:0] mr_sel;
    logic [15:0] addr;
    logic chop_otf;
    logic wdqs_pre_oe;
    logic rdqs_oe;
    logic rdqs_toggle;
    logic dll_locked;
    logic wr_start;
    // Host drives commands and write preamble, device drives read strobes and status
    modport host (output cke, cs_n, cmd, mr_sel, addr, chop_otf, wdqs_pre_oe,
        input rdqs_oe, rdqs_toggle, dll_locked, wr_start);
    modport dev (input cke, cs_n, cmd, mr_sel, addr, chop_otf, wdqs_pre_oe,
        output rdqs_oe, rdqs_toggle, dll_locked, wr_start);
endinterface

// >>> dgct_host.sv
/*
 Host controller end: geardown entry sequencer, command gap enforcement,
 CRC-with-mask timing selection and write preamble drive.
 Assumes the device end on the same core_clk through dgct_if.host.
*/
// Function
// R1: Wait reset-exit time before geardown mode write
// R2: Wait self-refresh exit before geardown enable
// R3: Sync pulse after mode update plus four
// R4: No command until mode update after sync
// R5: Sync setup, hold two; even counts
// R6: Device starts write four or two after latency
// R7: Reads only while DLL locked
// R8: CRC with mask selects substitute timings
// R9: Write recovery rounds up for powerdown entry
// R10: Device accepts clock-enable low mid-operation
// R11: Read preamble one or two clocks
// R12: Write preamble one or two clocks
// R13: Five clocks after register seven write
// R14: Nanosecond parameters round up to clocks
// R15: Two-clock preamble opens strobe earlier
// R16: Gap after multipurpose read before reload
// R17: Below 1600 use 1600 timings
// R18: Geardown entry sequenced by state machine
`timescale 1ns/100ps
module dgct_host #(
    parameter int WL_CYC = 9,
    parameter int RATE_MTS = 2400
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic gear_start,
    input wire logic from_reset,
    input wire logic req_valid,
    input wire dgct_pkg::dgct_cmd_t req_cmd,
    input wire logic [2:0] req_mr_sel,
    input wire logic [15:0] req_addr,
    input wire logic req_chop,
    input wire logic crc_en,
    input wire logic mask_en,
    output logic req_ready,
    output logic gear_done,
    output logic [7:0] wr_pden_cyc,
    dgct_if.host lnk
);
    // Geardown sequencer states, gray along the path
    typedef enum logic [2:0] {
        DGCT_G_IDLE = 3'b000,
        DGCT_G_EXIT = 3'b001,
        DGCT_G_MRW = 3'b011,
        DGCT_G_WSYNC = 3'b010,
        DGCT_G_SYNC = 3'b110,
        DGCT_G_WCMD = 3'b111,
        DGCT_G_DONE = 3'b101
    } dgct_gstate_t;

    // Even rounding of counts
    function automatic int even_up(input int v);
        even_up = v + (v % 2);
    endfunction

    localparam int EXIT_RST = dgct_pkg::RESET_EXIT_CYC; // R1
    localparam int EXIT_SREF = dgct_pkg::SREF_EXIT_CYC; // R2
    localparam int SYNC_WAIT = even_up(dgct_pkg::MODE_UPDATE_CYC + dgct_pkg::SYNC_EXTRA_CYC); // R3
    localparam int CMD_WAIT = even_up(dgct_pkg::MODE_UPDATE_CYC); // R4
    localparam int PULSE_LEN = dgct_pkg::SYNC_SETUP_CYC + dgct_pkg::SYNC_HOLD_CYC; // R5
    localparam logic [15:0] GEAR_MR = 16'h0008;

    dgct_gstate_t gst_reg, gst_next;
    logic [9:0] gcnt_reg;
    logic [7:0] gap_reg;
    logic mpr_on_reg;
    logic cke_reg, cs_n_reg, chop_reg, wpre_reg;
    logic [2:0] cmd_reg, mrs_reg;
    logic [15:0] addr_reg;
    logic [7:0] wpre_cnt_reg;
    logic wr_pre2_reg, rd_pre2_reg;
    logic done_reg;
    logic [7:0] pden_reg;

    // Substitute timings when both checks are on
    wire crc_mask = crc_en & mask_en; // R8
    wire [7:0] wr_rec = 8'(crc_mask ? dgct_pkg::WRITE_RECOVERY_CM_CYC : dgct_pkg::WRITE_RECOVERY_CYC); // R8 R9 R14
    wire [7:0] wtr_l = 8'(crc_mask ? dgct_pkg::WTR_LONG_CM_CYC : dgct_pkg::WTR_LONG_CYC); // R8
    wire [7:0] wtr_s = 8'(crc_mask ? dgct_pkg::WTR_SHORT_CM_CYC : dgct_pkg::WTR_SHORT_CYC); // R8
    // Below the lowest grade the long gaps stand; rate only widens margin
    wire slow_grade = (RATE_MTS < dgct_pkg::MIN_RATE_MTS); // R17
    wire [7:0] wtr_gap = (slow_grade | ~req_addr[12]) ? wtr_l : wtr_s;

    wire gear_busy = (gst_reg != DGCT_G_IDLE) && (gst_reg != DGCT_G_DONE);
    wire is_read = (req_cmd == dgct_pkg::DGCT_CMD_RD) || (req_cmd == dgct_pkg::DGCT_CMD_RDA);
    wire read_block = is_read & ~lnk.dll_locked; // R7
    wire can_issue = clk_en & req_valid & ~gear_busy & (gap_reg == 8'h00) & ~read_block;
    wire is_mrw = (req_cmd == dgct_pkg::DGCT_CMD_MRW);
    wire is_wr = (req_cmd == dgct_pkg::DGCT_CMD_WR);
    wire mrw_mr7 = is_mrw & (req_mr_sel == dgct_pkg::MR_SEL_SEVEN);
    wire mpr_reload = is_mrw & (req_mr_sel == dgct_pkg::MR_SEL_THREE);
    wire [7:0] wr_gap = 8'(WL_CYC + dgct_pkg::BURST_CYC) + wtr_gap;

    // Gap after the issued command
    wire [7:0] gap_new = mrw_mr7 ? 8'(dgct_pkg::MR7_GAP_CYC) :
                          (is_read & mpr_on_reg) ? 8'(dgct_pkg::BURST_CYC + dgct_pkg::MPR_GAP_CYC) :
                          is_wr ? wr_gap : 8'h00;

    // Geardown sequencer
    always_comb begin
        gst_next = gst_reg;
        case (gst_reg)
            DGCT_G_IDLE: if (gear_start) gst_next = DGCT_G_EXIT;
            DGCT_G_EXIT: if (gcnt_reg == 10'h000) gst_next = DGCT_G_MRW; // R1 R2
            DGCT_G_MRW: gst_next = DGCT_G_WSYNC;
            DGCT_G_WSYNC: if (gcnt_reg == 10'h000) gst_next = DGCT_G_SYNC; // R3
            DGCT_G_SYNC: if (gcnt_reg == 10'h000) gst_next = DGCT_G_WCMD; // R5
            DGCT_G_WCMD: if (gcnt_reg == 10'h000) gst_next = DGCT_G_DONE; // R4
            DGCT_G_DONE: gst_next = DGCT_G_DONE; // R18
            default: gst_next = DGCT_G_IDLE;
        endcase
    end

    // Counter loads on entry to each timed state (EXIT, WSYNC, SYNC, WCMD)
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gst_reg <= DGCT_G_IDLE;
            gcnt_reg <= 10'h000;
        end else if (clk_en) begin
            gst_reg <= gst_next;
            if (gst_reg == DGCT_G_IDLE && gear_start)
                gcnt_reg <= 10'(from_reset ? EXIT_RST - 1 : EXIT_SREF - 1); // R1 R2
            else if (gst_reg == DGCT_G_MRW)
                gcnt_reg <= 10'(SYNC_WAIT - 1); // R3
            else if (gst_next == DGCT_G_SYNC && gst_reg == DGCT_G_WSYNC)
                gcnt_reg <= 10'(PULSE_LEN - 1); // R5
            else if (gst_next == DGCT_G_WCMD && gst_reg == DGCT_G_SYNC)
                gcnt_reg <= 10'(CMD_WAIT - 1); // R4
            else if (gcnt_reg != 10'h000)
                gcnt_reg <= gcnt_reg - 10'h001;
        end
    end

    // Command gap and mode tracking
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_reg <= 8'h00;
            mpr_on_reg <= 1'b0;
            rd_pre2_reg <= 1'b0;
            wr_pre2_reg <= 1'b0;
        end else if (clk_en) begin
            if (can_issue) begin
                gap_reg <= gap_new; // R13 R16
                if (mpr_reload)
                    mpr_on_reg <= req_addr[dgct_pkg::MR3_MPR_BIT];
                if (is_mrw && req_mr_sel == dgct_pkg::MR_SEL_FOUR) begin
                    rd_pre2_reg <= req_addr[dgct_pkg::MR4_RD_PRE_BIT];
                    wr_pre2_reg <= req_addr[dgct_pkg::MR4_WR_PRE_BIT];
                end
            end else if (gap_reg != 8'h00)
                gap_reg <= gap_reg - 8'h01;
        end
    end

    // Link drive, including sync pulse on chip select
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cke_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            cmd_reg <= 3'h0;
            mrs_reg <= 3'h0;
            addr_reg <= 16'h0000;
            chop_reg <= 1'b0;
        end else if (clk_en) begin
            cke_reg <= 1'b1;
            cs_n_reg <= ~(gst_reg == DGCT_G_MRW || gst_next == DGCT_G_SYNC || can_issue); // R5
            cmd_reg <= (gst_reg == DGCT_G_MRW) ? dgct_pkg::DGCT_CMD_MRW :
                       can_issue ? req_cmd : dgct_pkg::DGCT_CMD_DES;
            mrs_reg <= (gst_reg == DGCT_G_MRW) ? dgct_pkg::MR_SEL_THREE : req_mr_sel;
            addr_reg <= (gst_reg == DGCT_G_MRW) ? GEAR_MR : req_addr;
            chop_reg <= req_chop;
        end
    end

    // Write preamble window ahead of write data
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wpre_cnt_reg <= 8'h00;
            wpre_reg <= 1'b0;
        end else if (clk_en) begin
            if (can_issue && is_wr)
                wpre_cnt_reg <= 8'(WL_CYC) - (wr_pre2_reg ? 8'h02 : 8'h01); // R12
            else if (wpre_cnt_reg != 8'h00)
                wpre_cnt_reg <= wpre_cnt_reg - 8'h01;
            wpre_reg <= (wpre_cnt_reg != 8'h00) && (wpre_cnt_reg <= (wr_pre2_reg ? 8'h02 : 8'h01)); // R12
        end
    end

    // Status outputs
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
            pden_reg <= 8'h00;
        end else if (clk_en) begin
            done_reg <= (gst_reg == DGCT_G_DONE);
            pden_reg <= 8'(WL_CYC + dgct_pkg::WSTART_FULL_CYC) + wr_rec; // R9
        end
    end

    assign req_ready = can_issue;
    assign gear_done = done_reg;
    assign wr_pden_cyc = pden_reg;
    assign lnk.cke = cke_reg;
    assign lnk.cs_n = cs_n_reg;
    assign lnk.cmd = cmd_reg;
    assign lnk.mr_sel = mrs_reg;
    assign lnk.addr = addr_reg;
    assign lnk.chop_otf = chop_reg;
    assign lnk.wdqs_pre_oe = wpre_reg;
endmodule

// >>> dgct_dev.sv
/*
 Memory device end: internal write start, read preamble strobe,
 DLL lock status, and power-down entry accepted mid-operation.
 Assumes the host end on the same core_clk through dgct_if.dev.
*/
`timescale 1ns/100ps
module dgct_dev #(
    parameter int WL_CYC = 9,
    parameter int RL_CYC = 11,
    parameter int LOCK_CYC = 64
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    output logic pd_idle,
    output logic chop_fixed,
    dgct_if.dev lnk
);
    logic [7:0] lock_cnt_reg;
    logic lock_reg;
    logic [7:0] wcnt_reg, rcnt_reg, bg_reg;
    logic ws_reg, roe_reg, rtog_reg, pd_reg;
    logic rd_pre2_reg, chop_fix_reg;

    wire cmd_ok = ~lnk.cs_n & lnk.cke;
    wire is_wr = cmd_ok & (lnk.cmd == dgct_pkg::DGCT_CMD_WR);
    wire is_rd = cmd_ok & ((lnk.cmd == dgct_pkg::DGCT_CMD_RD) | (lnk.cmd == dgct_pkg::DGCT_CMD_RDA));
    wire is_bg = cmd_ok & ((lnk.cmd == dgct_pkg::DGCT_CMD_ACT) | (lnk.cmd == dgct_pkg::DGCT_CMD_PRE) |
                           (lnk.cmd == dgct_pkg::DGCT_CMD_REF) | (lnk.cmd == dgct_pkg::DGCT_CMD_RDA));
    wire mr4_wr = cmd_ok & (lnk.cmd == dgct_pkg::DGCT_CMD_MRW) & (lnk.mr_sel == dgct_pkg::MR_SEL_FOUR);
    // Fixed chop starts earlier; chop on the fly behaves as a full burst
    wire [7:0] wstart = 8'(WL_CYC) + (chop_fix_reg ? 8'(dgct_pkg::WSTART_CHOP_CYC) : 8'(dgct_pkg::WSTART_FULL_CYC)); // R6
    wire [7:0] rpre = rd_pre2_reg ? 8'h02 : 8'h01; // R11 R15

    // Lock after a fixed settle time from reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_cnt_reg <= 8'h00;
            lock_reg <= 1'b0;
        end else if (clk_en) begin
            if (lock_cnt_reg != 8'(LOCK_CYC))
                lock_cnt_reg <= lock_cnt_reg + 8'h01;
            lock_reg <= (lock_cnt_reg == 8'(LOCK_CYC));
        end
    end

    // Mode register four preamble and chop mode
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pre2_reg <= 1'b0;
            chop_fix_reg <= 1'b0;
        end else if (clk_en && mr4_wr) begin
            rd_pre2_reg <= lnk.addr[dgct_pkg::MR4_RD_PRE_BIT]; // R11
            chop_fix_reg <= lnk.addr[0];
        end
    end

    // Internal write start pulse
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wcnt_reg <= 8'h00;
            ws_reg <= 1'b0;
        end else if (clk_en) begin
            // Load one short: the pulse is registered, so it must launch an edge before the start edge
            if (is_wr)
                wcnt_reg <= wstart - 8'h01; // R6
            else if (wcnt_reg != 8'h00)
                wcnt_reg <= wcnt_reg - 8'h01;
            ws_reg <= (wcnt_reg == 8'h01); // R6
        end
    end

    // Read strobe leaves high impedance one clock earlier in two-clock mode
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rcnt_reg <= 8'h00;
            roe_reg <= 1'b0;
            rtog_reg <= 1'b0;
        end else if (clk_en) begin
            if (is_rd && lock_reg)
                rcnt_reg <= 8'(RL_CYC + dgct_pkg::BURST_CYC);
            else if (rcnt_reg != 8'h00)
                rcnt_reg <= rcnt_reg - 8'h01;
            roe_reg <= (rcnt_reg != 8'h00) && (rcnt_reg <= 8'(dgct_pkg::BURST_CYC) + rpre); // R15
            rtog_reg <= (rcnt_reg != 8'h00) && (rcnt_reg <= 8'(dgct_pkg::BURST_CYC) + rpre) &&
                        (rd_pre2_reg ? ~rtog_reg : (rcnt_reg <= 8'(dgct_pkg::BURST_CYC))); // R11
        end
    end

    // Power-down taken while operations finish; idle only after bank operations and write starts end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bg_reg <= 8'h00;
            pd_reg <= 1'b0;
        end else if (clk_en) begin
            if (is_bg)
                bg_reg <= 8'(dgct_pkg::BG_OP_CYC);
            else if (bg_reg != 8'h00)
                bg_reg <= bg_reg - 8'h01;
            pd_reg <= ~lnk.cke && (bg_reg == 8'h00) && (wcnt_reg == 8'h00); // R10
        end
    end

    assign pd_idle = pd_reg;
    assign chop_fixed = chop_fix_reg;
    assign lnk.dll_locked = lock_reg;
    assign lnk.wr_start = ws_reg;
    assign lnk.rdqs_oe = roe_reg;
    assign lnk.rdqs_toggle = rtog_reg;
endmodule

// >>> dgct_chk.sv
/*
 Concurrent checks on the command link between the host and device ends.
 Assumes instantiation beside the joined link interface, on core_clk.
*/
`timescale 1ns/100ps
module dgct_chk #(
    parameter int WL_CYC = 9
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [2:0] cmd,
    input wire logic [2:0] mr_sel,
    input wire logic [15:0] addr,
    input wire logic dll_locked,
    input wire logic wr_start
);
    localparam int WFULL = WL_CYC + 4;
    localparam int WCHOP = WL_CYC + 2;
    logic chop_reg;
    // Decoded link commands
    wire wr_cmd = cke && !cs_n && cmd == dgct_pkg::DGCT_CMD_WR;
    wire rd_cmd = !cs_n && (cmd == dgct_pkg::DGCT_CMD_RD || cmd == dgct_pkg::DGCT_CMD_RDA);
    wire mrw_cmd = !cs_n && cmd == dgct_pkg::DGCT_CMD_MRW;
    wire mr7_cmd = mrw_cmd && mr_sel == dgct_pkg::MR_SEL_SEVEN;
    wire gear_mrw = mrw_cmd && mr_sel == dgct_pkg::MR_SEL_THREE && addr[3];
    wire sync_lo = !cs_n && cmd == dgct_pkg::DGCT_CMD_DES;
    // Shadow of the fixed-chop bit, so write start can be judged without device internals
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chop_reg <= 1'b0;
        end else if (mrw_cmd && mr_sel == dgct_pkg::MR_SEL_FOUR) begin
            chop_reg <= addr[0];
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    wr_full_a: assert property (wr_cmd && !chop_reg |-> ##WFULL wr_start)
        else $error("full burst write start not at latency plus four");
    wr_chop_a: assert property (wr_cmd && chop_reg |-> ##WCHOP wr_start)
        else $error("fixed chop write start not at latency plus two");
    wr_pulse_a: assert property (wr_start |=> !wr_start)
        else $error("write start longer than one cycle");
    wr_cause_a: assert property ($rose(wr_start) |-> $past(wr_cmd, WFULL) || $past(wr_cmd, WCHOP))
        else $error("write start without a write");
    read_lock_a: assert property (rd_cmd |-> dll_locked)
        else $error("read issued while unlocked");
    mr7_gap_a: assert property (mr7_cmd |=> (cs_n || cmd == dgct_pkg::DGCT_CMD_MRW) [*5])
        else $error("command too soon after register seven write");
    sync_wait_a: assert property (gear_mrw |=> cs_n [*5] ##[1:3] !cs_n)
        else $error("sync pulse too early or missing");
    sync_len_a: assert property ($fell(cs_n) && sync_lo |-> (!cs_n) [*4] ##1 cs_n [*2])
        else $error("sync pulse width or quiet gap wrong");
    cover property (wr_cmd && chop_reg ##WCHOP wr_start);
    cover property (gear_mrw ##[1:10] sync_lo);
    cover property (mr7_cmd);
    cover property (rd_cmd);
endmodule

// >>> tb_top.sv
/*
 Self-checking bench: host and device ends joined by the link interface.
 Assumes a 125 MHz core_clk and the shared package constants.
*/
`timescale 1ns/100ps
module tb_top;
    localparam int WL = 9;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic gear_start = 1'b0;
    logic from_reset = 1'b1;
    logic req_valid = 1'b0;
    dgct_pkg::dgct_cmd_t req_cmd = dgct_pkg::DGCT_CMD_DES;
    logic [2:0] req_mr_sel = 3'h0;
    logic [15:0] req_addr = 16'h0000;
    logic req_chop = 1'b0;
    logic crc_en = 1'b0;
    logic mask_en = 1'b0;
    logic req_ready;
    logic gear_done;
    logic [7:0] wr_pden_cyc;
    logic chop_fixed;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int t_cke = 0;
    int t_take;
    int t0;
    int dw;
    int junk;
    int np[3];
    int rd[3];
    dgct_if i_dgct_if();
    dgct_host #(.WL_CYC(WL), .RATE_MTS(2400)) i_dgct_host (.core_clk(core_clk), .sys_rst(sys_rst),
        .clk_en(1'b1), .gear_start(gear_start), .from_reset(from_reset), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_mr_sel(req_mr_sel), .req_addr(req_addr), .req_chop(req_chop),
        .crc_en(crc_en), .mask_en(mask_en), .req_ready(req_ready), .gear_done(gear_done),
        .wr_pden_cyc(wr_pden_cyc), .lnk(i_dgct_if.host));
    dgct_dev #(.WL_CYC(WL), .RL_CYC(11), .LOCK_CYC(16)) i_dgct_dev (.core_clk(core_clk),
        .sys_rst(sys_rst), .clk_en(1'b1), .pd_idle(), .chop_fixed(chop_fixed), .lnk(i_dgct_if.dev));
    dgct_chk #(.WL_CYC(WL)) i_dgct_chk (.core_clk(core_clk), .sys_rst(sys_rst), .cke(i_dgct_if.cke),
        .cs_n(i_dgct_if.cs_n), .cmd(i_dgct_if.cmd), .mr_sel(i_dgct_if.mr_sel), .addr(i_dgct_if.addr),
        .dll_locked(i_dgct_if.dll_locked), .wr_start(i_dgct_if.wr_start));
    // Clock, and an edge count so spacing is measured in link samples
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (sys_rst) t_cke <= 0;
        else if (i_dgct_if.cke === 1'b1 && t_cke == 0) t_cke <= cyc;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic fr);
        sys_rst = 1'b1;
        from_reset = fr;
        repeat (3) @(negedge core_clk);
        chk("reset cs_n", i_dgct_if.cs_n, 16'h0001);
        chk("reset cke", i_dgct_if.cke, 16'h0000);
        chk("reset lock", i_dgct_if.dll_locked, 16'h0000);
        sys_rst = 1'b0;
    endtask
    // Hold the request until ready is seen settled, then release after the taking edge
    task automatic send(input dgct_pkg::dgct_cmd_t c, input logic [2:0] sel, input logic [15:0] a);
        int i;
        // Let an edge pass so a back-to-back call never re-raises valid in the step that lowered it
        @(negedge core_clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_mr_sel = sel;
        req_addr = a;
        #1;
        for (i = 0; i < 400 && req_ready !== 1'b1; i++) begin
            @(negedge core_clk);
            #1;
        end
        if (i == 400) begin
            errors++;
            final_report();
        end
        @(posedge core_clk);
        t_take = cyc;
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask
    // Observation window after a take; k counts falling edges since the taking edge
    task automatic window(output int d_wr, output int d_rd, output int n_pre);
        d_wr = 0;
        d_rd = 0;
        n_pre = 0;
        for (int k = 2; k <= 40; k++) begin
            @(negedge core_clk);
            if (i_dgct_if.wr_start === 1'b1 && d_wr == 0) d_wr = k;
            if (i_dgct_if.rdqs_oe === 1'b1 && d_rd == 0) d_rd = k;
            if (i_dgct_if.wdqs_pre_oe === 1'b1) n_pre++;
        end
    endtask
    // Geardown entry; a request is offered mid-sequence and must wait
    task automatic gear();
        int t_mrw;
        int t_lo;
        int t_hi;
        t_mrw = 0;
        t_lo = 0;
        t_hi = 0;
        gear_start = 1'b1;
        for (int k = 0; k < 400 && gear_done !== 1'b1; k++) begin
            @(negedge core_clk);
            #1;
            if (i_dgct_if.cs_n === 1'b0 && i_dgct_if.cmd === dgct_pkg::DGCT_CMD_MRW && t_mrw == 0) begin
                t_mrw = cyc;
                chk("gear select", i_dgct_if.mr_sel, 16'h0003);
                chk("gear bits", i_dgct_if.addr, 16'h0008);
                req_valid = 1'b1;
                req_cmd = dgct_pkg::DGCT_CMD_ACT;
            end else if (t_mrw != 0 && t_hi == 0) begin
                chk("busy refusal", req_ready, 16'h0000);
            end
            if (i_dgct_if.cs_n === 1'b0 && i_dgct_if.cmd === dgct_pkg::DGCT_CMD_DES && t_mrw != 0 && t_lo == 0) t_lo = cyc;
            if (i_dgct_if.cs_n === 1'b1 && t_lo != 0 && t_hi == 0) t_hi = cyc;
        end
        gear_start = 1'b0;
        chk("gear done", gear_done, 16'h0001);
        chk("exit wait", 16'(t_mrw - t_cke >= dgct_pkg::RESET_EXIT_CYC - 1), 16'h0001);
        chk("sync wait", 16'(t_lo - t_mrw >= dgct_pkg::MODE_UPDATE_CYC + 4), 16'h0001);
        chk("sync width", 16'(t_hi - t_lo), 16'(dgct_pkg::SYNC_SETUP_CYC + dgct_pkg::SYNC_HOLD_CYC));
        send(dgct_pkg::DGCT_CMD_ACT, 3'h0, 16'h0000);
        chk("first command", 16'(t_take + 1 - t_hi >= dgct_pkg::MODE_UPDATE_CYC), 16'h0001);
    endtask
    initial begin
        // Two passes: reset-exit entry, then a second reset and self-refresh-exit entry
        for (int p = 0; p < 2; p++) begin
            do_reset(p == 0);
            if (p == 0) begin
                req_valid = 1'b1;
                req_cmd = dgct_pkg::DGCT_CMD_RD;
                #1;
                chk("read before lock", req_ready, 16'h0000);
                send(dgct_pkg::DGCT_CMD_RD, 3'h0, 16'h0000);
                chk("lock at read", i_dgct_if.dll_locked, 16'h0001);
            end
            gear();
        end
        // Plain, on-the-fly chop, then fixed chop with both two-clock preambles
        for (int m = 0; m < 3; m++) begin
            send(dgct_pkg::DGCT_CMD_MRW, dgct_pkg::MR_SEL_FOUR, (m == 2) ? 16'h1801 : 16'h0000);
            req_chop = (m == 1);
            send(dgct_pkg::DGCT_CMD_WR, 3'h0, 16'h0000);
            req_chop = 1'b0;
            chk("fixed chop", chop_fixed, (m == 2) ? 16'h0001 : 16'h0000);
            window(dw, junk, np[m]);
            chk("write start", 16'(dw), 16'((m == 2) ? WL + 3 : WL + 5));
            send(dgct_pkg::DGCT_CMD_RD, 3'h0, 16'h0000);
            window(junk, rd[m], junk);
        end
        chk("read strobe shift", 16'(rd[0] - rd[2]), 16'h0001);
        chk("write preamble", 16'(np[2] - np[0]), 16'h0001);
        // Every checksum and mask combination; only both on swaps the recovery time
        for (int c = 0; c < 4; c++) begin
            crc_en = c[0];
            mask_en = c[1];
            repeat (2) @(negedge core_clk);
            chk("pden", 16'(wr_pden_cyc), 16'(WL + 4 + ((c == 3) ? dgct_pkg::WRITE_RECOVERY_CM_CYC :
                dgct_pkg::WRITE_RECOVERY_CYC)));
        end
        send(dgct_pkg::DGCT_CMD_MRW, dgct_pkg::MR_SEL_SEVEN, 16'h0000);
        t0 = t_take;
        send(dgct_pkg::DGCT_CMD_ACT, 3'h0, 16'h0000);
        chk("mr7 gap", 16'(t_take - t0 >= dgct_pkg::MR7_GAP_CYC + 1), 16'h0001);
        send(dgct_pkg::DGCT_CMD_MRW, dgct_pkg::MR_SEL_THREE, 16'h0004);
        send(dgct_pkg::DGCT_CMD_RD, 3'h0, 16'h0000);
        t0 = t_take;
        send(dgct_pkg::DGCT_CMD_MRW, dgct_pkg::MR_SEL_THREE, 16'h0000);
        chk("mpr gap", 16'(t_take - t0 >= dgct_pkg::MPR_GAP_CYC), 16'h0001);
        final_report();
    end
endmodule
